// *** can_cfg.svh ***
// constants for the can bit-rate and mailbox mode block
`ifndef CAN_CFG_SVH
`define CAN_CFG_SVH

`define CFG_PRESC_W 10
`define CFG_PRESC_RESET 10'h000
`define CFG_TQ_W 5
`define CFG_TQ_MIN 5'h08
`define CFG_TQ_MAX 5'h19
`define CFG_TQ_RESET 5'h08
`define CFG_MB_NUM 64
`define CFG_MB_IDX_W 6
`define CFG_ID_W 29
`define CFG_BUF_DEPTH 2
`define CFG_CTL_TX_POS 2
`define CFG_CTL_RX_POS 1
`define CFG_CTL_ONE_POS 0
`define CFG_CTL_RESET 3'h0

`endif

// *** can_pkg.sv ***
// types shared by the can bit-rate and mailbox mode block
`include "can_cfg.svh"

package can_pkg;

    typedef enum logic [1:0] {
        MODE_RESET,
        MODE_HALT,
        MODE_OPERATE
    } op_mode_e;

    typedef enum logic [2:0] {
        MB_DISABLED,
        MB_ABORT_SINGLE_ATTEMPT_BIT,
        MB_RX,
        MB_RX_SINGLE_ATTEMPT_BIT,
        MB_TX,
        MB_TX_SINGLE_ATTEMPT_BIT,
        MB_FORBIDDEN
    } mb_mode_e;

    // control bits of one mailbox, tx on top
    typedef struct packed {
        logic transmit_request_bit;
        logic receive_request_bit;
        logic single_attempt_bit;
    } mailbox_control_reg_s;

    typedef struct packed {
        logic [`CFG_ID_W-1:0] id;
        logic from_self;
        logic [`CFG_MB_NUM-1:0] hit;
    } rx_frame_s;

    typedef struct packed {
        logic [`CFG_MB_IDX_W-1:0] idx;
        logic [`CFG_ID_W-1:0] id;
        logic fifo;
    } rx_entry_s;

    localparam int ENTRY_W = $bits(rx_entry_s);

endpackage

// *** msg_buffer.sv ***
// small valid/ready buffer of flip-flops
`timescale 1ns/1ns

module msg_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0] count;
        logic not_full;
        logic not_empty;
    } buf_state_s;

    buf_state_s state_reg;
    buf_state_s state_next;
    logic push;
    logic pop;
    logic [CW-1:0] slot;

    assign push = in_valid && state_reg.not_full;
    assign pop = out_ready && state_reg.not_empty;

    // head always sits in entry 0, so the outputs come straight from flops
    always_comb begin
        state_next = state_reg;
        slot = state_reg.count;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                state_next.mem[i] = state_reg.mem[i + 1];
            end
            slot = CW'(state_reg.count - 1'b1);
        end
        if (push) begin
            state_next.mem[slot] = in_data;
        end
        case ({push, pop})
            2'b10: state_next.count = CW'(state_reg.count + 1'b1);
            2'b01: state_next.count = CW'(state_reg.count - 1'b1);
            default: state_next.count = state_reg.count;
        endcase
        state_next.not_full = (state_next.count != CW'(DEPTH));
        state_next.not_empty = (state_next.count != '0);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.not_full <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign in_ready = state_reg.not_full;
    assign out_valid = state_reg.not_empty;
    assign out_data = state_reg.mem[0];

endmodule

// *** can_bitrate_mailbox.sv ***
// can bit-rate prescaler, operating modes and mailbox mode decoding
//
// Function
// RULE1 - bit rate is clock over prescale times tq
// RULE2 - prescaler divides by setting plus one, 0-1023
// RULE3 - software sets timing only in configuration
// RULE4 - arrangement select: 0 normal, 1 fifo
// RULE5 - all three bits clear: disabled or aborting
// RULE6 - only single-attempt: one-shot abort in progress
// RULE7 - receive bit receives; with single-attempt one-shot
// RULE8 - transmit bit transmits; with single-attempt one-shot
// RULE9 - software clears control before receive setup
// RULE10 - store in lowest matching receive mailbox
// RULE11 - normal mode never receives own frame
// RULE12 - self-test may receive own frame, acknowledges
// RULE13 - software checks control zero before transmit setup
// RULE14 - reset mode clears all settings
// RULE15 - software changes bit rate via reset mode
// RULE16 - halt mode stops, keeps configuration
// RULE17 - software never sets transmit and receive together
// RULE18 - status shows mode change completion
`timescale 1ns/1ns

module can_bitrate_mailbox
    import can_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mode_req_valid,
    input wire op_mode_e mode_req,
    input wire logic [`CFG_PRESC_W-1:0] presc_setting,
    input wire logic [`CFG_TQ_W-1:0] tq_per_bit,
    input wire logic mailbox_arrangement_select,
    input wire logic self_test_req,
    input wire logic mb_wr,
    input wire logic [`CFG_MB_IDX_W-1:0] mb_wr_idx,
    input wire mailbox_control_reg_s mb_wr_ctl,
    input wire logic [`CFG_MB_IDX_W-1:0] mb_rd_idx,
    input wire logic rx_valid,
    input wire rx_frame_s rx_frame,
    output logic rx_ready,
    output logic out_valid,
    output rx_entry_s out_entry,
    input wire logic out_ready,
    output op_mode_e mode_status,
    output logic mode_busy,
    output logic tq_tick,
    output logic bit_tick,
    output logic self_ack,
    output logic rx_missed,
    output logic mb_wr_err,
    output mailbox_control_reg_s mb_rd_ctl,
    output mb_mode_e mb_rd_mode
);

    // ********************************************************
    // state
    // ********************************************************

    typedef struct packed {
        op_mode_e mode;
        op_mode_e pending;
        logic switching;
        logic [`CFG_PRESC_W-1:0] presc;
        logic [`CFG_TQ_W-1:0] tq_num;
        logic [`CFG_PRESC_W-1:0] presc_cnt;
        logic [`CFG_TQ_W-1:0] tq_cnt;
        logic tq_tick;
        logic bit_tick;
        logic arrangement;
        logic self_test;
        logic [`CFG_MB_NUM-1:0][2:0] ctl;
        logic [`CFG_MB_NUM-1:0] rx_hold;
        logic self_ack;
        logic rx_missed;
        logic wr_err;
        mailbox_control_reg_s rd_ctl;
        mb_mode_e rd_mode;
    } top_state_s;

    top_state_s state_reg;
    top_state_s state_next;

    logic accept;
    logic push;
    rx_entry_s push_entry;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [ENTRY_W-1:0] buf_out_data;

    // ********************************************************
    // helpers
    // ********************************************************

    // RULE5 RULE6 mode decoding
    function automatic mb_mode_e decode_mode(input logic [2:0] c);
        case (c)
            3'h0: decode_mode = MB_DISABLED;
            3'h1: decode_mode = MB_ABORT_SINGLE_ATTEMPT_BIT;
            // RULE7 receive encodings
            3'h2: decode_mode = MB_RX;
            3'h3: decode_mode = MB_RX_SINGLE_ATTEMPT_BIT;
            // RULE8 transmit encodings
            3'h4: decode_mode = MB_TX;
            3'h5: decode_mode = MB_TX_SINGLE_ATTEMPT_BIT;
            default: decode_mode = MB_FORBIDDEN;
        endcase
    endfunction

    function automatic logic [`CFG_TQ_W-1:0] clamp_tq(input logic [`CFG_TQ_W-1:0] n);
        if (n < `CFG_TQ_MIN) begin
            clamp_tq = `CFG_TQ_MIN;
        end else if (n > `CFG_TQ_MAX) begin
            clamp_tq = `CFG_TQ_MAX;
        end else begin
            clamp_tq = n;
        end
    endfunction

    // lowest set bit wins
    function automatic logic [`CFG_MB_IDX_W:0] first_set(input logic [`CFG_MB_NUM-1:0] v);
        first_set = '0;
        for (int i = `CFG_MB_NUM - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = {1'b1, `CFG_MB_IDX_W'(i)};
            end
        end
    endfunction

    // ********************************************************
    // receive selection
    // ********************************************************

    logic [`CFG_MB_NUM-1:0] eligible;
    logic [`CFG_MB_IDX_W:0] pick;
    logic own_allowed;

    // RULE11 own frames only in self-test
    assign own_allowed = !rx_frame.from_self || state_reg.self_test;
    assign accept = rx_valid && buf_in_ready;

    always_comb begin
        eligible = '0;
        for (int i = 0; i < `CFG_MB_NUM; i++) begin
            // one-shot receive mailbox waits for software after one frame
            eligible[i] = rx_frame.hit[i]
                && (decode_mode(state_reg.ctl[i]) == MB_RX
                || (decode_mode(state_reg.ctl[i]) == MB_RX_SINGLE_ATTEMPT_BIT && !state_reg.rx_hold[i]));
        end
    end

    // RULE10 lowest-numbered match
    assign pick = first_set(eligible);

    always_comb begin
        push = 1'b0;
        push_entry = '0;
        push_entry.id = rx_frame.id;
        if (accept && state_reg.mode == MODE_OPERATE && own_allowed) begin
            // RULE4 fifo arrangement bypasses mailbox search
            if (state_reg.arrangement) begin
                push = 1'b1;
                push_entry.fifo = 1'b1;
            end else if (pick[`CFG_MB_IDX_W]) begin
                push = 1'b1;
                push_entry.idx = pick[`CFG_MB_IDX_W-1:0];
            end
        end
    end

    // ********************************************************
    // next state
    // ********************************************************

    always_comb begin
        state_next = state_reg;
        state_next.tq_tick = 1'b0;
        state_next.bit_tick = 1'b0;
        state_next.self_ack = 1'b0;
        state_next.rx_missed = 1'b0;
        state_next.wr_err = 1'b0;

        // RULE1 RULE2 tq every presc+1 clocks, bit every tq_num tq
        if (state_reg.mode == MODE_OPERATE) begin
            if (state_reg.presc_cnt == state_reg.presc) begin
                state_next.presc_cnt = '0;
                state_next.tq_tick = 1'b1;
                if (state_reg.tq_cnt == `CFG_TQ_W'(state_reg.tq_num - 1'b1)) begin
                    state_next.tq_cnt = '0;
                    state_next.bit_tick = 1'b1;
                end else begin
                    state_next.tq_cnt = `CFG_TQ_W'(state_reg.tq_cnt + 1'b1);
                end
            end else begin
                state_next.presc_cnt = `CFG_PRESC_W'(state_reg.presc_cnt + 1'b1);
            end
        end else begin
            state_next.presc_cnt = '0;
            state_next.tq_cnt = '0;
        end

        // RULE3 RULE15 timing and arrangement only follow inputs in reset mode
        if (state_reg.mode == MODE_RESET) begin
            state_next.presc = presc_setting;
            state_next.tq_num = clamp_tq(tq_per_bit);
            state_next.arrangement = mailbox_arrangement_select;
            state_next.self_test = self_test_req;
        end

        // mailbox control writes; forbidden combinations are refused
        if (mb_wr) begin
            if (mb_wr_ctl.transmit_request_bit && mb_wr_ctl.receive_request_bit) begin
                // RULE17 refuse transmit plus receive
                state_next.wr_err = 1'b1;
            end else begin
                state_next.ctl[mb_wr_idx] = mb_wr_ctl;
                state_next.rx_hold[mb_wr_idx] = 1'b0;
            end
        end

        if (push && !state_reg.arrangement
            && decode_mode(state_reg.ctl[push_entry.idx]) == MB_RX_SINGLE_ATTEMPT_BIT) begin
            state_next.rx_hold[push_entry.idx] = 1'b1;
        end

        // RULE12 acknowledge own frame taken in self-test
        if (push && rx_frame.from_self) begin
            state_next.self_ack = 1'b1;
        end
        if (accept && !push) begin
            state_next.rx_missed = 1'b1;
        end

        // RULE18 switch settles at a bit boundary while operating
        if (mode_req_valid) begin
            state_next.pending = mode_req;
            state_next.switching = 1'b1;
        end else if (state_reg.switching
            && (state_reg.mode != MODE_OPERATE || state_reg.bit_tick)) begin
            state_next.mode = state_reg.pending;
            state_next.switching = 1'b0;
            // RULE14 reset mode clears settings
            if (state_reg.pending == MODE_RESET) begin
                state_next.presc = `CFG_PRESC_RESET;
                state_next.tq_num = `CFG_TQ_RESET;
                state_next.arrangement = 1'b0;
                state_next.self_test = 1'b0;
                state_next.rx_hold = '0;
                for (int i = 0; i < `CFG_MB_NUM; i++) begin
                    state_next.ctl[i] = `CFG_CTL_RESET;
                end
            end
            // RULE16 halt keeps configuration, counters stop above
        end

        state_next.rd_ctl = state_next.ctl[mb_rd_idx];
        state_next.rd_mode = decode_mode(state_next.ctl[mb_rd_idx]);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.mode <= MODE_RESET;
            state_reg.pending <= MODE_RESET;
            state_reg.presc <= `CFG_PRESC_RESET;
            state_reg.tq_num <= `CFG_TQ_RESET;
            state_reg.rd_mode <= MB_DISABLED;
        end else begin
            state_reg <= state_next;
        end
    end

    // ********************************************************
    // output buffer
    // ********************************************************

    // a stalled reader holds two entries; further frames wait on rx_ready
    msg_buffer #(
        .WIDTH(ENTRY_W),
        .DEPTH(`CFG_BUF_DEPTH)
    ) u_buffer (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(push),
        .in_data(push_entry),
        .in_ready(buf_in_ready),
        .out_valid(buf_out_valid),
        .out_data(buf_out_data),
        .out_ready(out_ready)
    );

    assign rx_ready = buf_in_ready;
    assign out_valid = buf_out_valid;
    assign out_entry = rx_entry_s'(buf_out_data);
    assign mode_status = state_reg.mode;
    assign mode_busy = state_reg.switching;
    assign tq_tick = state_reg.tq_tick;
    assign bit_tick = state_reg.bit_tick;
    assign self_ack = state_reg.self_ack;
    assign rx_missed = state_reg.rx_missed;
    assign mb_wr_err = state_reg.wr_err;
    assign mb_rd_ctl = state_reg.rd_ctl;
    assign mb_rd_mode = state_reg.rd_mode;

endmodule

// *** can_bitrate_mailbox_monitor.sv ***
// port checks for the can bit-rate and mailbox mode block
`timescale 1ns/1ns

module can_bitrate_mailbox_monitor
    import can_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mode_req_valid,
    input wire logic mb_wr,
    input wire mailbox_control_reg_s mb_wr_ctl,
    input wire logic rx_valid,
    input wire rx_frame_s rx_frame,
    input wire logic rx_ready,
    input wire logic out_valid,
    input wire rx_entry_s out_entry,
    input wire logic out_ready,
    input wire op_mode_e mode_status,
    input wire logic mode_busy,
    input wire logic tq_tick,
    input wire logic bit_tick,
    input wire logic self_ack,
    input wire logic rx_missed,
    input wire logic mb_wr_err
);
    // ****
    // checks
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_wr_both_refused: assert property (mb_wr && mb_wr_ctl.transmit_request_bit
        && mb_wr_ctl.receive_request_bit |=> mb_wr_err) else $error("tx rx write not refused");
    a_err_has_cause: assert property (mb_wr_err |-> $past(mb_wr))
        else $error("write error without write");
    a_busy_after_req: assert property (mode_req_valid |=> mode_busy)
        else $error("mode request not shown busy");
    a_switch_done: assert property (mode_busy && !mode_req_valid &&
        mode_status != MODE_OPERATE |=> !mode_busy) else $error("idle switch too slow");
    a_bit_on_tq: assert property (bit_tick |-> tq_tick)
        else $error("bit tick off a tq tick");
    a_no_tick_idle: assert property ((mode_status != MODE_OPERATE) [*2] |-> !tq_tick)
        else $error("tq tick outside operation");
    a_missed_idle: assert property (rx_valid && rx_ready &&
        mode_status != MODE_OPERATE |=> rx_missed) else $error("frame taken while stopped");
    a_ack_own: assert property (self_ack |->
        $past(rx_valid && rx_ready && rx_frame.from_self)) else $error("ack without own frame");
    a_out_held: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_entry)) else $error("stalled entry changed");
endmodule

bind can_bitrate_mailbox can_bitrate_mailbox_monitor mon_u (.clk(clk), .reset_n(reset_n),
    .mode_req_valid(mode_req_valid), .mb_wr(mb_wr), .mb_wr_ctl(mb_wr_ctl),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready), .out_valid(out_valid),
    .out_entry(out_entry), .out_ready(out_ready), .mode_status(mode_status),
    .mode_busy(mode_busy), .tq_tick(tq_tick), .bit_tick(bit_tick), .self_ack(self_ack),
    .rx_missed(rx_missed), .mb_wr_err(mb_wr_err));

// *** can_node_model.sv ***
// other bus nodes: frame source and a consumer of stored entries
`timescale 1ns/1ns

module can_node_model
    import can_pkg::*;
(
    input wire logic clk,
    output logic rx_valid,
    output rx_frame_s rx_frame,
    input wire logic rx_ready,
    input wire logic out_valid,
    input wire rx_entry_s out_entry,
    output logic out_ready
);
    logic stall = 1'b0;
    rx_entry_s got_q[$];

    initial begin
        rx_valid = 1'b0;
        rx_frame = '0;
    end
    assign out_ready = !stall;

    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            got_q.push_back(out_entry);
        end
    end

    // frame is held until rx_ready is seen at an edge
    task automatic send(input rx_frame_s f);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        rx_valid = 1'b1;
        rx_frame = f;
        // ready is a flop: its settled value is what the next edge samples
        while (rx_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        rx_valid = 1'b0;
        // released lines show garbage, not the old frame
        rx_frame = ~f;
        if (n == 50) begin
            tb_can_bitrate_mailbox.err_total++;
            tb_can_bitrate_mailbox.conclude();
        end
    endtask
endmodule

// *** tb_can_bitrate_mailbox.sv ***
// self-checking bench of the can bit-rate and mailbox mode block
`timescale 1ns/1ns
`include "can_cfg.svh"

module tb_can_bitrate_mailbox;
    import can_pkg::*;
    logic clk, reset_n, mode_req_valid, self_test_req, mb_wr, rx_valid, rx_ready, out_valid;
    logic out_ready, mode_busy, tq_tick, bit_tick, self_ack, rx_missed, mb_wr_err, arr_sel;
    op_mode_e mode_req, mode_status;
    logic [`CFG_PRESC_W-1:0] presc_setting;
    logic [`CFG_TQ_W-1:0] tq_per_bit;
    logic [`CFG_MB_IDX_W-1:0] mb_wr_idx, mb_rd_idx;
    mailbox_control_reg_s mb_wr_ctl, mb_rd_ctl;
    mb_mode_e mb_rd_mode;
    rx_frame_s rx_frame;
    rx_entry_s out_entry;
    int err_total = 0;
    int total_checks = 0;
    mb_mode_e exp_mb [8] = '{MB_DISABLED, MB_ABORT_SINGLE_ATTEMPT_BIT, MB_RX, MB_RX_SINGLE_ATTEMPT_BIT, MB_TX,
        MB_TX_SINGLE_ATTEMPT_BIT, MB_DISABLED, MB_DISABLED};

    can_bitrate_mailbox dut_u (.clk(clk), .reset_n(reset_n), .mode_req_valid(mode_req_valid),
        .mode_req(mode_req), .presc_setting(presc_setting), .tq_per_bit(tq_per_bit),
        .mailbox_arrangement_select(arr_sel), .self_test_req(self_test_req), .mb_wr(mb_wr),
        .mb_wr_idx(mb_wr_idx), .mb_wr_ctl(mb_wr_ctl), .mb_rd_idx(mb_rd_idx),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready), .out_valid(out_valid),
        .out_entry(out_entry), .out_ready(out_ready), .mode_status(mode_status),
        .mode_busy(mode_busy), .tq_tick(tq_tick), .bit_tick(bit_tick), .self_ack(self_ack),
        .rx_missed(rx_missed), .mb_wr_err(mb_wr_err), .mb_rd_ctl(mb_rd_ctl),
        .mb_rd_mode(mb_rd_mode));
    can_node_model node_u (.clk(clk), .rx_valid(rx_valid), .rx_frame(rx_frame),
        .rx_ready(rx_ready), .out_valid(out_valid), .out_entry(out_entry),
        .out_ready(out_ready));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****
    // tasks
    // ****
    task automatic conclude();
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic g, input logic e, input string m);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic chk_mb(input mb_mode_e g, input mb_mode_e e);
        chk_bit(g === e, 1'b1, "mailbox mode");
    endtask
    task automatic chk_ent(input logic [5:0] i, input logic [28:0] d, input logic f);
        int n;
        n = 0;
        while (node_u.got_q.size() == 0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk_bit(n < 20 && node_u.got_q.pop_front() === {i, d, f}, 1'b1, "stored entry");
        if (n == 20) conclude();
    endtask
    function automatic rx_frame_s frm(input logic [63:0] h, input logic s);
        frm.id = h[28:0];
        frm.from_self = s;
        frm.hit = h;
    endfunction
    task automatic set_mode(input op_mode_e m);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        mode_req_valid = 1'b1;
        mode_req = m;
        @(posedge clk);
        #1;
        mode_req_valid = 1'b0;
        while ((mode_status !== m || mode_busy !== 1'b0) && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_bit(n < 2000, 1'b1, "mode switch");
        if (n == 2000) conclude();
    endtask
    task automatic wr(input logic [5:0] i, input logic [2:0] c);
        @(posedge clk);
        #1;
        mb_wr = 1'b1;
        mb_wr_idx = i;
        mb_wr_ctl = c;
        mb_rd_idx = i;
        @(posedge clk);
        #1;
        mb_wr = 1'b0;
    endtask
    // spacing between two pulses of one tick
    task automatic gap(input logic b, input int e);
        int n, k;
        n = 0;
        k = 0;
        while (k < 2 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
            if ((b ? bit_tick : tq_tick) === 1'b1) begin
                k++;
                if (k == 1) n = 0;
            end
        end
        chk_bit(n == e, 1'b1, "tick spacing");
        if (k < 2) conclude();
    endtask

    // ****
    // sequence
    // ****
    initial begin
        {reset_n, mode_req_valid, self_test_req, mb_wr, arr_sel} = '0;
        mode_req = MODE_RESET;
        presc_setting = 10'h000;
        tq_per_bit = 5'h08;
        mb_wr_idx = 6'h00;
        mb_wr_ctl = 3'h0;
        mb_rd_idx = 6'h00;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        chk_bit(rx_ready, 1'b1, "ready after reset");
        chk_mb(mb_rd_mode, MB_DISABLED);
        for (int c = 0; c < 8; c++) begin
            wr(6'h03, 3'h0);
            wr(6'h03, c[2:0]);
            chk_bit(mb_wr_err, c > 5, "forbidden write");
            chk_mb(mb_rd_mode, exp_mb[c]);
            chk_bit(mb_rd_ctl === (c > 5 ? 3'h0 : c[2:0]), 1'b1, "control view");
        end
        presc_setting = 10'h003;
        wr(6'h03, 3'h0);
        wr(6'h02, 3'h2);
        wr(6'h05, 3'h2);
        wr(6'h07, 3'h3);
        set_mode(MODE_OPERATE);
        gap(1'b0, 4);
        gap(1'b1, 32);
        node_u.send(frm(64'h24, 1'b0));
        chk_ent(6'h02, 29'h24, 1'b0);
        node_u.send(frm(64'h80, 1'b0));
        chk_ent(6'h07, 29'h80, 1'b0);
        node_u.send(frm(64'h80, 1'b0));
        chk_bit(rx_missed, 1'b1, "one-shot taken twice");
        node_u.send(frm(64'h04, 1'b1));
        chk_bit(rx_missed, 1'b1, "own frame stored");
        node_u.stall = 1'b1;
        node_u.send(frm(64'h04, 1'b0));
        node_u.send(frm(64'h20, 1'b0));
        chk_bit(rx_ready, 1'b0, "full buffer ready");
        node_u.stall = 1'b0;
        chk_ent(6'h02, 29'h04, 1'b0);
        chk_ent(6'h05, 29'h20, 1'b0);
        set_mode(MODE_HALT);
        node_u.send(frm(64'h04, 1'b0));
        chk_bit(rx_missed, 1'b1, "stored while halted");
        chk_mb(mb_rd_mode, MB_RX_SINGLE_ATTEMPT_BIT);
        set_mode(MODE_OPERATE);
        node_u.send(frm(64'h20, 1'b0));
        chk_ent(6'h05, 29'h20, 1'b0);
        set_mode(MODE_RESET);
        chk_mb(mb_rd_mode, MB_DISABLED);
        presc_setting = 10'h001;
        tq_per_bit = 5'h09;
        self_test_req = 1'b1;
        wr(6'h02, 3'h2);
        set_mode(MODE_OPERATE);
        gap(1'b0, 2);
        gap(1'b1, 18);
        node_u.send(frm(64'h04, 1'b1));
        chk_bit(self_ack, 1'b1, "own frame ack");
        chk_ent(6'h02, 29'h04, 1'b0);
        set_mode(MODE_RESET);
        arr_sel = 1'b1;
        self_test_req = 1'b0;
        wr(6'h04, 3'h2);
        set_mode(MODE_OPERATE);
        node_u.send(frm(64'h10, 1'b0));
        chk_ent(6'h00, 29'h10, 1'b1);
        conclude();
    end
endmodule
